// file: pkg/smsc_pkg.sv
// Purpose: shared constants and types of the serial master status/control block
// Assumes: 8-bit multiplexed host bus, low address byte selects the register
// Notes:   offsets are low address bytes; the high byte is matched to a base value
package smsc_pkg;

  // ----------------------------------------
  // register offsets (low address byte)
  // ----------------------------------------
  localparam logic [7:0] SMSC_STATUS_OFS  = 8'h80;
  localparam logic [7:0] SMSC_CONTROL_OFS = 8'h84;
  localparam logic [7:0] SMSC_TXDATA_OFS  = 8'h8A;
  localparam logic [7:0] SMSC_RXDATA_OFS  = 8'h8E;

  // ----------------------------------------
  // serial_status field positions
  // ----------------------------------------
  localparam int SMSC_ST_DONE_BIT  = 7;
  localparam int SMSC_ST_ERR_BIT   = 6;
  localparam int SMSC_ST_BUSY_BIT  = 5;
  localparam int SMSC_ST_INTN_BIT  = 4;
  localparam int SMSC_ST_TXE_BIT   = 3;
  localparam int SMSC_ST_RXF_BIT   = 2;

  // ----------------------------------------
  // serial_control field positions and reset
  // ----------------------------------------
  localparam int         SMSC_CT_EN_BIT    = 7;
  localparam int         SMSC_CT_INTERRUPT_ENABLE_SETTING_BIT = 6;
  localparam int         SMSC_CT_START_BIT = 5;
  localparam int         SMSC_CT_CFG_W     = 5;
  localparam logic [7:0] SMSC_CONTROL_RST  = 8'h00;
  localparam logic [7:0] SMSC_DATA_RST     = 8'h00;

  // ----------------------------------------
  // synchroniser depth for pin inputs
  // ----------------------------------------
  localparam int SMSC_SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    SMSC_IDLE,
    SMSC_DECODE,
    SMSC_XFER,
    SMSC_END
  } smsc_bus_e;

  // host bus pins and slave-select after synchronisation
  typedef struct packed {
    logic       ale_n;
    logic       rd_n;
    logic       wr_n;
    logic       ss_n;
    logic [7:0] addr_hi;
    logic [7:0] ad;
  } smsc_pins_s;

  localparam int SMSC_PINS_W = $bits(smsc_pins_s);
  localparam logic [SMSC_PINS_W-1:0] SMSC_PINS_IDLE = {4'hF, 8'h00, 8'h00};

endpackage : smsc_pkg

// file: verilog/smsc_pin_sync.sv
// Purpose: three-stage synchroniser with agreement filter for host pins
// Assumes: inputs are asynchronous to clk_in
// Notes:   output only moves when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module smsc_pin_sync
  import smsc_pkg::*;
#(
  parameter int                WIDTH    = 8,
  parameter logic [WIDTH-1:0]  IDLE_VAL = '0
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_r <= IDLE_VAL;
      s2_r <= IDLE_VAL;
      s3_r <= IDLE_VAL;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // per bit: a change counts only once the last two stages agree
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          sync_out[gi] <= IDLE_VAL[gi];
        end else if (s2_r[gi] == s3_r[gi]) begin
          sync_out[gi] <= s3_r[gi];
        end
      end
    end
  endgenerate

endmodule : smsc_pin_sync
`default_nettype wire

// file: verilog/smsc_top.sv
// Purpose: status and control registers of a serial master, reached over a multiplexed host bus
// Assumes: shifter, clock divider and slave-select logic sit outside and share clk_in
// Notes:   host bus pins are synchronised; read data is driven only while in XFER, until strobe release
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1 - host software should check bus busy is clear before starting a new transaction
// R2 - status bit 4 reads low while interrupt pending; request only when enabled
// R3 - pending set when transmit register empty while transfer-run bit is 1
// R4 - pending set when receive register full while transfer-run bit is 0
// R5 - pending set on any serial bus error
// R6 - pending cleared by transmit write, receive read, or error clear
// R7 - transmit-empty at bit 3 set when no word waiting, cleared by host write
// R8 - receive-full at bit 2 set on unread word, cleared by host read
// R9 - transmit-empty and receive-full also drive dedicated output pins
// R10 - status bits 1-0 always read zero
// R11 - other control bits ignored unless enable bit 7 set; clearing it resets core
// R12 - slave-select input sets error bit 6, resets and tristates serial side; write 0 clears
// R13 - rising transfer-run bit starts shifting when transmit not empty; host clears after last word
// R14 - interrupt enable bit 6 gates request without clearing pending cause
// R15 - reset clears error and pending, transmit empty, receive not full, master disabled
module smsc_top
  import smsc_pkg::*;
#(
  parameter logic [7:0] BASE_HI = 8'h00
) (
  input  wire logic                     clk_in,
  input  wire logic                     rst_n_in,
  // host multiplexed bus
  input  wire logic                     ale_n_in,
  input  wire logic                     rd_n_in,
  input  wire logic                     wr_n_in,
  input  wire logic [7:0]               addr_hi_in,
  input  wire logic [7:0]               ad_in,
  output logic      [7:0]               ad_out,
  output logic                          ad_oe_n_out,
  output logic                          irq_n_out,
  // pins of the serial side
  input  wire logic                     slave_sel_n_in,
  output logic                          transmit_empty_flag_out,
  output logic                          receive_full_flag_out,
  // shifter core, same clock
  input  wire logic                     bus_busy_in,
  input  wire logic                     done_in,
  input  wire logic                     tx_taken_in,
  input  wire logic                     rx_valid_in,
  input  wire logic [7:0]               rx_data_in,
  output logic [7:0]                    tx_data_out,
  output logic                          tx_ready_out,
  output logic                          start_out,
  output logic                          core_enable_out,
  output logic                          serial_tristate_out,
  output logic [SMSC_CT_CFG_W-1:0]      core_cfg_out
);

  // ----------------------------------------
  // pin synchronisation
  // ----------------------------------------
  smsc_pins_s pins;
  logic [SMSC_PINS_W-1:0] pins_raw;
  logic [SMSC_PINS_W-1:0] pins_sync;

  assign pins_raw = {ale_n_in, rd_n_in, wr_n_in, slave_sel_n_in, addr_hi_in, ad_in};
  assign pins     = smsc_pins_s'(pins_sync);

  smsc_pin_sync #(
    .WIDTH    (SMSC_PINS_W),
    .IDLE_VAL (SMSC_PINS_IDLE)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .async_in (pins_raw),
    .sync_out (pins_sync)
  );

  // ----------------------------------------
  // host bus state machine
  // ----------------------------------------
  smsc_bus_e  state_r;
  logic [7:0] addr_r;
  logic       sel_r;
  logic       acc_rd;
  logic       acc_wr;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= SMSC_IDLE;
      addr_r  <= SMSC_DATA_RST;
      sel_r   <= 1'b0;
    end else begin
      unique case (state_r)
        SMSC_IDLE: begin
          if (!pins.ale_n) begin
            state_r <= SMSC_DECODE;
            addr_r  <= pins.ad;
            sel_r   <= (pins.addr_hi == BASE_HI);
          end
        end
        SMSC_DECODE: begin
          if (pins.ale_n) begin
            state_r <= SMSC_IDLE;
          end else if (sel_r && (!pins.rd_n || !pins.wr_n)) begin
            state_r <= SMSC_XFER;
          end
        end
        SMSC_XFER: begin
          if (pins.rd_n && pins.wr_n) begin
            state_r <= SMSC_END;
          end
        end
        SMSC_END: begin
          if (pins.ale_n) begin
            state_r <= SMSC_IDLE;
          end
        end
      endcase
    end
  end

  // one-cycle access pulses on entry to the transfer state
  assign acc_rd = (state_r == SMSC_DECODE) && sel_r && !pins.ale_n && !pins.rd_n;
  assign acc_wr = (state_r == SMSC_DECODE) && sel_r && !pins.ale_n && pins.rd_n && !pins.wr_n;

  logic wr_tx;
  logic wr_ctl;
  logic wr_st;
  logic rd_rx;
  assign wr_tx  = acc_wr && (addr_r == SMSC_TXDATA_OFS);
  assign wr_ctl = acc_wr && (addr_r == SMSC_CONTROL_OFS);
  assign wr_st  = acc_wr && (addr_r == SMSC_STATUS_OFS);
  assign rd_rx  = acc_rd && (addr_r == SMSC_RXDATA_OFS);

  // ----------------------------------------
  // control register
  // ----------------------------------------
  logic [7:0] control_r;
  logic       enable;
  logic       start_en;
  logic       start_q_r;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      control_r <= SMSC_CONTROL_RST; // [R15]
    end else if (wr_ctl) begin
      control_r <= pins.ad;
    end
  end

  assign enable   = control_r[SMSC_CT_EN_BIT];
  assign start_en = enable && control_r[SMSC_CT_START_BIT]; // [R11]

  // ----------------------------------------
  // status flags and data registers
  // ----------------------------------------
  logic       err_r;
  logic       txe_r;
  logic       rxf_r;
  logic       pend_r;
  logic [7:0] tx_r;
  logic [7:0] rx_r;
  logic       err_set;
  logic       err_clr;
  logic       cond_tx;
  logic       cond_rx;
  logic       cond_tx_q_r;
  logic       cond_rx_q_r;
  logic       pend_set;
  logic       pend_clr;

  // error only counts while enabled; slave-select is sampled as a level, so a held assertion keeps setting it
  assign err_set = enable && !pins.ss_n; // [R12]
  assign err_clr = wr_st && !pins.ad[SMSC_ST_ERR_BIT]; // [R12]

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      err_r <= 1'b0; // [R15]
    end else if (!enable) begin
      err_r <= 1'b0; // [R11]
    end else if (err_set) begin
      err_r <= 1'b1; // set wins over the software clear
    end else if (err_clr) begin
      err_r <= 1'b0;
    end
  end

  // transmit holding register: host write fills, shifter take empties
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      txe_r <= 1'b1; // [R15]
      tx_r  <= SMSC_DATA_RST;
    end else if (!enable) begin
      txe_r <= 1'b1; // [R11]
    end else if (wr_tx) begin
      txe_r <= 1'b0; // [R7]
      tx_r  <= pins.ad;
    end else if (tx_taken_in && !err_r) begin
      txe_r <= 1'b1; // [R7]
    end
  end

  // receive register: a new word outranks a read in the same cycle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rxf_r <= 1'b0; // [R15]
      rx_r  <= SMSC_DATA_RST;
    end else if (!enable) begin
      rxf_r <= 1'b0; // [R11]
    end else if (rx_valid_in && !err_r) begin
      rxf_r <= 1'b1; // [R8]
      rx_r  <= rx_data_in;
    end else if (rd_rx) begin
      rxf_r <= 1'b0; // [R8]
    end
  end

  // pending is raised when a cause first appears, so a host action can release it
  assign cond_tx  = txe_r && start_en; // [R3]
  assign cond_rx  = rxf_r && enable && !control_r[SMSC_CT_START_BIT]; // [R4]
  assign pend_set = (cond_tx && !cond_tx_q_r) || (cond_rx && !cond_rx_q_r) || (err_set && !err_r); // [R5]
  assign pend_clr = wr_tx || rd_rx || err_clr; // [R6]

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cond_tx_q_r <= 1'b0;
      cond_rx_q_r <= 1'b0;
    end else begin
      cond_tx_q_r <= cond_tx;
      cond_rx_q_r <= cond_rx;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pend_r <= 1'b0; // [R15]
    end else if (!enable) begin
      pend_r <= 1'b0; // [R11]
    end else if (pend_set) begin
      pend_r <= 1'b1; // [R3] [R4] [R5]
    end else if (pend_clr) begin
      pend_r <= 1'b0; // [R6]
    end
  end

  // ----------------------------------------
  // read data and bus drive
  // ----------------------------------------
  logic [7:0] status;
  logic [7:0] rd_data;

  always_comb begin
    status                   = 8'h00; // [R10]
    status[SMSC_ST_DONE_BIT] = done_in;
    status[SMSC_ST_ERR_BIT]  = err_r;
    status[SMSC_ST_BUSY_BIT] = bus_busy_in;
    status[SMSC_ST_INTN_BIT] = !pend_r; // [R2]
    status[SMSC_ST_TXE_BIT]  = txe_r; // [R7]
    status[SMSC_ST_RXF_BIT]  = rxf_r; // [R8]
    unique case (addr_r)
      SMSC_STATUS_OFS:  rd_data = status;
      SMSC_CONTROL_OFS: rd_data = control_r;
      SMSC_TXDATA_OFS:  rd_data = tx_r;
      SMSC_RXDATA_OFS:  rd_data = rx_r;
      default:          rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ad_out      <= 8'h00;
      ad_oe_n_out <= 1'b1;
    end else if (acc_rd) begin
      ad_out      <= rd_data;
      ad_oe_n_out <= 1'b0;
    end else if (state_r != SMSC_XFER || pins.rd_n) begin
      ad_oe_n_out <= 1'b1;
    end
  end

  // ----------------------------------------
  // outputs to pins and shifter core
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_n_out               <= 1'b1;
      transmit_empty_flag_out <= 1'b1;
      receive_full_flag_out   <= 1'b0;
      tx_data_out             <= SMSC_DATA_RST;
      tx_ready_out            <= 1'b0;
      start_out               <= 1'b0;
      start_q_r               <= 1'b0;
      core_enable_out         <= 1'b0;
      serial_tristate_out     <= 1'b1;
      core_cfg_out            <= '0;
    end else begin
      irq_n_out               <= !(pend_r && enable && control_r[SMSC_CT_INTERRUPT_ENABLE_SETTING_BIT]); // [R2] [R14]
      transmit_empty_flag_out <= txe_r; // [R9]
      receive_full_flag_out   <= rxf_r; // [R9]
      tx_data_out             <= tx_r;
      start_q_r               <= start_en;
      // shifting is offered while the run bit is set, at its rise or any later cycle, when a word is waiting
      if (start_en && !start_q_r) begin
        tx_ready_out <= !txe_r && !wr_tx; // [R13]
      end else if (!start_en || err_r) begin
        tx_ready_out <= 1'b0;
      end else if (!tx_ready_out && start_q_r) begin
        tx_ready_out <= !txe_r && !wr_tx; // [R13]
      end else if (tx_taken_in) begin
        tx_ready_out <= 1'b0;
      end
      start_out               <= start_en && !err_r; // [R13]
      core_enable_out         <= enable && !err_r; // [R11] [R12]
      serial_tristate_out     <= !enable || err_r; // [R12]
      core_cfg_out            <= enable ? control_r[SMSC_CT_CFG_W-1:0] : '0; // [R11]
    end
  end

endmodule : smsc_top
`default_nettype wire

// file: verif/smsc_checker.sv
// Purpose: port-level assertions for the serial master status/control block
// Assumes: one clock domain, reset active low and asynchronous
// Notes:   bound to smsc_top below; sees only its ports
`timescale 1ns/1ps
`default_nettype none
module smsc_checker
  import smsc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ale_n_in,
  input wire logic rd_n_in,
  input wire logic ad_oe_n_out,
  input wire logic irq_n_out,
  input wire logic transmit_empty_flag_out,
  input wire logic receive_full_flag_out,
  input wire logic tx_taken_in,
  input wire logic rx_valid_in,
  input wire logic tx_ready_out,
  input wire logic start_out,
  input wire logic core_enable_out,
  input wire logic serial_tristate_out
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_take;
    tx_taken_in && tx_ready_out && core_enable_out;
  endsequence
  sequence s_fill;
    rx_valid_in && core_enable_out;
  endsequence

  property p_rst_state;
    !$past(rst_n_in) |-> transmit_empty_flag_out && !receive_full_flag_out && irq_n_out && serial_tristate_out;
  endproperty
  a_rst_state: assert property (p_rst_state) else $error("state after reset wrong");
  property p_tx_empty;
    s_take |-> ##[1:3] transmit_empty_flag_out;
  endproperty
  a_tx_empty: assert property (p_tx_empty) else $error("transmit empty pin not set");
  property p_rx_full;
    s_fill |-> ##[1:3] receive_full_flag_out;
  endproperty
  a_rx_full: assert property (p_rx_full) else $error("receive full pin not set");
  property p_ready_drop;
    s_take |-> ##[1:2] !tx_ready_out;
  endproperty
  a_ready_drop: assert property (p_ready_drop) else $error("offer held after take");
  property p_ready_word;
    $rose(tx_ready_out) |-> !transmit_empty_flag_out;
  endproperty
  a_ready_word: assert property (p_ready_word) else $error("offer with empty register");
  property p_start_gate;
    start_out |-> core_enable_out;
  endproperty
  a_start_gate: assert property (p_start_gate) else $error("run while disabled");
  property p_tristate;
    serial_tristate_out != core_enable_out;
  endproperty
  a_tristate: assert property (p_tristate) else $error("tristate disagrees with enable");
  property p_tx_write_rel;
    $fell(transmit_empty_flag_out) |-> ##[0:2] irq_n_out;
  endproperty
  a_tx_write_rel: assert property (p_tx_write_rel) else $error("irq kept after transmit write");
  property p_rd_drive;
    $fell(ad_oe_n_out) |-> !rd_n_in && !ale_n_in;
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("bus driven outside a read");
endmodule : smsc_checker

bind smsc_top smsc_checker chk_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .ale_n_in(ale_n_in), .rd_n_in(rd_n_in),
  .ad_oe_n_out(ad_oe_n_out), .irq_n_out(irq_n_out), .transmit_empty_flag_out(transmit_empty_flag_out),
  .receive_full_flag_out(receive_full_flag_out), .tx_taken_in(tx_taken_in), .rx_valid_in(rx_valid_in),
  .tx_ready_out(tx_ready_out), .start_out(start_out), .core_enable_out(core_enable_out),
  .serial_tristate_out(serial_tristate_out));
`default_nettype wire

// file: verif/smsc_host_model.sv
// Purpose: microcontroller on the multiplexed host bus
// Assumes: each pin level held at least 6 clocks, well above the 3-clock filter
// Notes:   a released bus toggles every cycle so stale data cannot match
`timescale 1ns/1ps
`default_nettype none
module smsc_host_model
  import smsc_pkg::*;
#(
  parameter logic [7:0] BASE = 8'h00
) (
  input  wire logic       clk_in,
  input  wire logic [7:0] dev_ad_in,
  input  wire logic       dev_oe_n_in,
  output logic            ale_n_out,
  output logic            rd_n_out,
  output logic            wr_n_out,
  output logic [7:0]      addr_hi_out,
  output logic [7:0]      bus_out
);
  logic       host_en;
  logic [7:0] host_ad;
  logic [7:0] last = 8'h00;

  assign bus_out = !dev_oe_n_in ? dev_ad_in : (host_en ? host_ad : ~last);
  always @(posedge clk_in) last <= bus_out;
  initial begin
    {ale_n_out, rd_n_out, wr_n_out, host_en} = 4'hE;
    addr_hi_out = 8'h00;
    host_ad = 8'h00;
  end

  task access(input logic wr, input logic [7:0] ofs, input logic [7:0] wd, output logic [7:0] rd);
    @(posedge clk_in); #1;
    ale_n_out = 1'b0;
    addr_hi_out = BASE;
    host_ad = ofs;
    host_en = 1'b1;
    repeat (6) @(posedge clk_in); #1;
    if (wr) begin
      host_ad = wd;
      wr_n_out = 1'b0;
    end else begin
      host_en = 1'b0;
      rd_n_out = 1'b0;
    end
    repeat (9) @(posedge clk_in);
    rd = bus_out;
    #1;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    repeat (6) @(posedge clk_in); #1;
    ale_n_out = 1'b1;
    host_en = 1'b0;
    // return off the edge so callers sample settled outputs and drive inputs safely
    repeat (6) @(posedge clk_in); #1;
  endtask : access
endmodule : smsc_host_model
`default_nettype wire

// file: verif/tb_spi_master_status_control.sv
// Purpose: register-level tests of the status/control block through the host bus
// Assumes: shifter signals driven here, one clock
// Notes:   expectations written as literal values or SMSC_CONTROL_RST, not built from field positions
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_spi_master_status_control;
  import smsc_pkg::*;
  logic clk, rst_n, ale_n, rd_n, wr_n, oe_n, irq_n, ss_n, txe, rxf, busy, done, taken, rxv;
  logic rdy, start, cen, tri_s;
  logic [7:0] hi, bus, dout, rxd, txd;
  logic [4:0] cfg;
  int error_cnt, compares;

  smsc_top dut_u (.clk_in(clk), .rst_n_in(rst_n), .ale_n_in(ale_n), .rd_n_in(rd_n), .wr_n_in(wr_n),
    .addr_hi_in(hi), .ad_in(bus), .ad_out(dout), .ad_oe_n_out(oe_n), .irq_n_out(irq_n),
    .slave_sel_n_in(ss_n), .transmit_empty_flag_out(txe), .receive_full_flag_out(rxf), .bus_busy_in(busy),
    .done_in(done), .tx_taken_in(taken), .rx_valid_in(rxv), .rx_data_in(rxd), .tx_data_out(txd),
    .tx_ready_out(rdy), .start_out(start), .core_enable_out(cen), .serial_tristate_out(tri_s),
    .core_cfg_out(cfg));
  smsc_host_model host_u (.clk_in(clk), .dev_ad_in(dout), .dev_oe_n_in(oe_n), .ale_n_out(ale_n),
    .rd_n_out(rd_n), .wr_n_out(wr_n), .addr_hi_out(hi), .bus_out(bus));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task wr(input logic [7:0] o, input logic [7:0] d);
    logic [7:0] x;
    host_u.access(1'b1, o, d, x);
  endtask : wr
  task rdm(input logic [7:0] o, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] x;
    host_u.access(1'b0, o, 8'h00, x);
    `CHK(x & m, e)
  endtask : rdm
  task pulse(input int sel);
    @(posedge clk); #1;
    if (sel == 0) taken = 1'b1; else rxv = 1'b1;
    @(posedge clk); #1;
    {taken, rxv} = 2'b00;
    repeat (4) @(posedge clk);
  endtask : pulse
  task stop_test;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #50000;
    error_cnt++;
    stop_test();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {rst_n, ss_n, busy, done, taken, rxv} = 6'b010000;
    rxd = 8'h00;
    error_cnt = 0;
    compares = 0;
    repeat (20) @(posedge clk); #1;
    rst_n = 1'b1;
    repeat (6) @(posedge clk);
    rdm(SMSC_STATUS_OFS, 8'hFF, 8'h18);
    rdm(SMSC_CONTROL_OFS, 8'hFF, SMSC_CONTROL_RST);
    rdm(8'h88, 8'hFF, 8'h00);
    `CHK({txe, rxf, cen}, 3'b100)
    $display("test reset done");
    // host polls busy before any setup
    {busy, done} = 2'b11;
    rdm(SMSC_STATUS_OFS, 8'hA0, 8'hA0);
    {busy, done} = 2'b00;
    wr(SMSC_CONTROL_OFS, 8'h1F);
    `CHK({cen, cfg}, 6'h00)
    rdm(SMSC_CONTROL_OFS, 8'hFF, 8'h1F);
    wr(SMSC_CONTROL_OFS, 8'hC3);
    `CHK({cen, tri_s, cfg}, 7'b1000011)
    $display("test enable done");
    wr(SMSC_TXDATA_OFS, 8'h5A);
    `CHK({txd, txe}, 9'h0B4)
    rdm(SMSC_STATUS_OFS, 8'hFF, 8'h10);
    wr(SMSC_CONTROL_OFS, 8'hE0);
    `CHK({rdy, start}, 2'b11)
    pulse(0);
    rdm(SMSC_STATUS_OFS, 8'hFF, 8'h08);
    `CHK(irq_n, 1'b0)
    wr(SMSC_CONTROL_OFS, 8'hA0);
    `CHK(irq_n, 1'b1)
    rdm(SMSC_STATUS_OFS, 8'hFF, 8'h08);
    wr(SMSC_TXDATA_OFS, 8'h11);
    rdm(SMSC_STATUS_OFS, 8'hFF, 8'h10);
    $display("test transmit done");
    wr(SMSC_CONTROL_OFS, 8'hC0);
    rxd = 8'h3C;
    pulse(1);
    rdm(SMSC_STATUS_OFS, 8'hFF, 8'h04);
    `CHK({rxf, irq_n}, 2'b10)
    rdm(SMSC_RXDATA_OFS, 8'hFF, 8'h3C);
    rdm(SMSC_STATUS_OFS, 8'hFF, 8'h10);
    $display("test receive done");
    @(posedge clk); #1;
    ss_n = 1'b0;
    repeat (10) @(posedge clk); #1;
    ss_n = 1'b1;
    repeat (6) @(posedge clk); #1;
    `CHK({tri_s, cen, irq_n}, 3'b100)
    rdm(SMSC_STATUS_OFS, 8'h50, 8'h40);
    wr(SMSC_STATUS_OFS, 8'h00);
    rdm(SMSC_STATUS_OFS, 8'h50, 8'h10);
    $display("test error done");
    wr(SMSC_CONTROL_OFS, 8'h00);
    rdm(SMSC_STATUS_OFS, 8'hFF, 8'h18);
    `CHK({cen, tri_s, txe}, 3'b011)
    $display("test disable done");
    stop_test();
  end
endmodule : tb_spi_master_status_control
`undef CHK
`default_nettype wire
